//--- rtl/dsp_pkg.sv
// Constants, register map and field layout of the debug serial port
// What this block does
// - Receive character ready raises the receive transfer channel request
// - Transmit holding free raises the transmit transfer channel request
// - Transfer channel registers start at offset 0x100, handled outside
// - Transfer channel flags appear in status and can raise the interrupt
// - Mode bits 15:14 select normal, echo, local loop or remote loop
// - Echo mode copies serial input to output; transmitter hidden from pin
// - Local loop feeds transmitter into receiver, output pin held high
// - Remote loop wires input pin to output pin; receiver idle, transmitter still shifts off the pin
// - Debug channel read and write pending shown on status bits 31, 30
// - Two hard-wired identity registers; second reads zero without extension flag
// - First identity register holds constant extension, memory, set, ram, cpu, revision
// - Force tap reset bit holds tap reset low; resets to zero
// - Command bit 2 resets and disables receiver, aborting its character
// - Command bit 3 resets and disables transmitter, aborting its character
// - Enable bits 4 and 6 act only when matching disable is clear
// - Receiver disable at bit 5 lets a character in progress finish
// - Transmitter disable at bit 7 finishes shifting and holding characters first
// - Command bit 8 clears check bit, framing and overrun error flags
// - Mode bits 11:9 choose even, odd, zero, one or no check bit
// - Interrupt set register writes of one set mask bits
// - Interrupt clear register writes of one clear mask bits
// - Mask view reads enabled sources, resets to zero
// - Bit clock is master clock over sixteen times divisor; zero stops it
// - Ready flag set on character transfer, cleared by reading received character
// - Frame: low start, eight data bits LSB first, optional check, high stop
package dsp_pkg;
  localparam logic [7:0] OFF_COMMAND  = 8'h00;
  localparam logic [7:0] OFF_SETUP    = 8'h04;
  localparam logic [7:0] OFF_IRQ_SET  = 8'h08;
  localparam logic [7:0] OFF_IRQ_CLR  = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_FLAGS    = 8'h14;
  localparam logic [7:0] OFF_RX_CHAR  = 8'h18;
  localparam logic [7:0] OFF_TX_CHAR  = 8'h1C;
  localparam logic [7:0] OFF_DIVISOR  = 8'h20;
  localparam logic [7:0] OFF_ID       = 8'h40;
  localparam logic [7:0] OFF_ID_EXTRA = 8'h44;
  localparam logic [7:0] OFF_TAP_LOCK = 8'h48;
  localparam logic [8:0] OFF_CHANNEL  = 9'h100;
  localparam int CMD_RX_RST = 2;
  localparam int CMD_TX_RST = 3;
  localparam int CMD_RX_ON  = 4;
  localparam int CMD_RX_OFF = 5;
  localparam int CMD_TX_ON  = 6;
  localparam int CMD_TX_OFF = 7;
  localparam int CMD_ERR_CLR = 8;
  localparam int SETUP_MODE_LSB = 14;
  localparam int SETUP_CHK_LSB  = 9;
  localparam int FL_RX_READY  = 0;
  localparam int FL_TX_FREE   = 1;
  localparam int FL_RX_DONE   = 3;
  localparam int FL_TX_DONE   = 4;
  localparam int FL_OVERRUN   = 5;
  localparam int FL_FRAMING   = 6;
  localparam int FL_CHECK     = 7;
  localparam int FL_TX_IDLE   = 9;
  localparam int FL_TX_BUFE   = 11;
  localparam int FL_RX_BUFF   = 12;
  localparam int FL_DCC_WR    = 30;
  localparam int FL_DCC_RD    = 31;
  localparam logic [31:0] SRC_MASK   = 32'hC000_1AFB;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  localparam logic [4:0] START_DET  = 5'h08;
  localparam logic [4:0] HALF_BIT   = 5'h08;
  localparam logic [4:0] FULL_BIT   = 5'h10;
  localparam logic [3:0] DATA_BITS  = 4'h8;
  // Arbitrary neutral identity value
  localparam logic [31:0] ID_VALUE   = 32'h8000_1234;
  localparam logic [31:0] ID_EXTRA   = 32'h0000_0001;
  typedef enum logic [1:0] {
    DSP_MODE_NORMAL = 2'b00,
    DSP_MODE_ECHO   = 2'b01,
    DSP_MODE_LOCAL  = 2'b10,
    DSP_MODE_REMOTE = 2'b11
  } dsp_mode_e;
  typedef enum logic [2:0] {
    DSP_PH_IDLE  = 3'b000,
    DSP_PH_START = 3'b001,
    DSP_PH_DATA  = 3'b010,
    DSP_PH_CHECK = 3'b011,
    DSP_PH_STOP  = 3'b100
  } dsp_phase_e;
endpackage : dsp_pkg

//--- rtl/dsp_debug_port.sv
// Debug serial port: register file, baud generator, receiver, transmitter, test modes
`timescale 1ns/1ps
`default_nettype none
module dsp_debug_port (
  input  wire logic                   clock_in,
  input  wire logic                   nrst_in,
  input  wire logic [7:0]             addr_in,
  input  wire logic [31:0]            wdata_in,
  input  wire logic                   write_in,
  input  wire logic                   read_in,
  output logic      [31:0]            rdata_out,
  input  wire logic                   serial_in_pin_in,
  output logic                        serial_out_pin_out,
  input  wire logic                   dcc_read_pending_in,
  input  wire logic                   dcc_write_pending_in,
  input  wire logic                   rx_channel_done_in,
  input  wire logic                   tx_channel_done_in,
  input  wire logic                   tx_channel_buffer_empty_in,
  input  wire logic                   rx_channel_buffer_full_in,
  output logic                        rx_channel_req_out,
  output logic                        tx_channel_req_out,
  output logic                        tap_reset_n_out,
  output logic                        irq_out
);
  import dsp_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [31:0] rdata;
    logic [15:0] setup;
    logic [15:0] divisor;
    logic [31:0] mask;
    logic        tap_lock;
    logic [15:0] div_cnt;
    logic [2:0]  sync;
    logic        rx_line;
    logic        rx_en;
    logic        rx_stop_pend;
    dsp_phase_e  rx_ph;
    logic [4:0]  rx_tick;
    logic [3:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        rx_par;
    logic [7:0]  rx_char;
    logic        rx_ready;
    logic        err_ovr;
    logic        err_frm;
    logic        err_chk;
    logic        tx_en;
    logic        tx_stop_pend;
    dsp_phase_e  tx_ph;
    logic [3:0]  tx_tick;
    logic [3:0]  tx_bit;
    logic [7:0]  tx_sh;
    logic        tx_par;
    logic [7:0]  tx_hold;
    logic        tx_hold_full;
    logic        tx_line;
    logic        out_pin;
  } dsp_state_s;

  dsp_state_s s_reg;
  dsp_state_s s_next;

  function automatic logic check_bit(input logic [2:0] kind, input logic [7:0] d);
    case (kind[1:0])
      2'b00:   check_bit = ^d;
      2'b01:   check_bit = ~(^d);
      2'b10:   check_bit = 1'b0;
      default: check_bit = 1'b1;
    endcase
  endfunction : check_bit

  logic [31:0] flags;
  logic        samp_en;
  logic        rx_src;
  logic        wr_cmd;
  logic        rx_done;
  logic [2:0]  chk_kind;
  dsp_mode_e   mode;

  assign mode     = dsp_mode_e'(s_reg.setup[SETUP_MODE_LSB +: 2]);
  assign chk_kind = s_reg.setup[SETUP_CHK_LSB +: 3];
  assign wr_cmd   = write_in && (addr_in == OFF_COMMAND);
  // Sample tick each divisor cycles, so a bit lasts sixteen of them
  assign samp_en  = (s_reg.divisor != 16'h0000) && (s_reg.div_cnt == 16'h0001);
  assign rx_src   = (mode == DSP_MODE_LOCAL) ? s_reg.tx_line : s_reg.rx_line;
  // Stop bit sampled now: a new character lands this cycle
  assign rx_done  = s_reg.rx_en && samp_en && (mode != DSP_MODE_REMOTE) &&
                    (s_reg.rx_ph == DSP_PH_STOP) && (s_reg.rx_tick == FULL_BIT);

  always_comb begin
    flags = RESET_ZERO;
    flags[FL_RX_READY] = s_reg.rx_ready;
    flags[FL_TX_FREE]  = s_reg.tx_en && !s_reg.tx_hold_full;
    flags[FL_RX_DONE]  = rx_channel_done_in;
    flags[FL_TX_DONE]  = tx_channel_done_in;
    flags[FL_OVERRUN]  = s_reg.err_ovr;
    flags[FL_FRAMING]  = s_reg.err_frm;
    flags[FL_CHECK]    = s_reg.err_chk;
    flags[FL_TX_IDLE]  = s_reg.tx_en && !s_reg.tx_hold_full && (s_reg.tx_ph == DSP_PH_IDLE);
    flags[FL_TX_BUFE]  = tx_channel_buffer_empty_in;
    flags[FL_RX_BUFF]  = rx_channel_buffer_full_in;
    flags[FL_DCC_WR]   = dcc_write_pending_in;
    flags[FL_DCC_RD]   = dcc_read_pending_in;
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.sync    = {s_reg.sync[1:0], serial_in_pin_in};
    // Line changes only once the last two stages agree
    if (s_reg.sync[2] == s_reg.sync[1]) begin
      s_next.rx_line = s_reg.sync[2];
    end
    s_next.div_cnt = samp_en ? s_reg.divisor :
                     (s_reg.div_cnt == 16'h0000 ? s_reg.divisor : s_reg.div_cnt - 16'h0001);
    s_next.rdata = RESET_ZERO;

    // ---- Register reads
    if (read_in) begin
      if (addr_in == OFF_SETUP) begin
        s_next.rdata = {16'h0000, s_reg.setup};
      end else if (addr_in == OFF_IRQ_MASK) begin
        s_next.rdata = s_reg.mask;
      end else if (addr_in == OFF_FLAGS) begin
        s_next.rdata = flags;
      end else if (addr_in == OFF_RX_CHAR) begin
        s_next.rdata    = {24'h00_0000, s_reg.rx_char};
        s_next.rx_ready = 1'b0;
      end else if (addr_in == OFF_DIVISOR) begin
        s_next.rdata = {16'h0000, s_reg.divisor};
      end else if (addr_in == OFF_ID) begin
        s_next.rdata = ID_VALUE;
      end else if (addr_in == OFF_ID_EXTRA) begin
        s_next.rdata = ID_VALUE[31] ? ID_EXTRA : RESET_ZERO;
      end else if (addr_in == OFF_TAP_LOCK) begin
        s_next.rdata = {31'h0000_0000, s_reg.tap_lock};
      end else begin
        s_next.rdata = RESET_ZERO;
      end
    end

    // ---- Register writes
    if (write_in) begin
      if (addr_in == OFF_SETUP) begin
        s_next.setup = wdata_in[15:0] & 16'hCE00;
      end else if (addr_in == OFF_IRQ_SET) begin
        s_next.mask = s_reg.mask | (wdata_in & SRC_MASK);
      end else if (addr_in == OFF_IRQ_CLR) begin
        s_next.mask = s_reg.mask & ~wdata_in;
      end else if (addr_in == OFF_DIVISOR) begin
        s_next.divisor = wdata_in[15:0];
      end else if (addr_in == OFF_TAP_LOCK) begin
        s_next.tap_lock = wdata_in[0];
      end else if (addr_in == OFF_TX_CHAR && s_reg.tx_en) begin
        s_next.tx_hold      = wdata_in[7:0];
        s_next.tx_hold_full = 1'b1;
      end
    end

    // Clear ahead of the receiver, so an error raised in the same cycle survives
    if (wr_cmd && wdata_in[CMD_ERR_CLR]) begin
      s_next.err_ovr = 1'b0;
      s_next.err_frm = 1'b0;
      s_next.err_chk = 1'b0;
    end

    // ---- Receiver
    if (s_reg.rx_en && samp_en && mode != DSP_MODE_REMOTE) begin
      s_next.rx_tick = s_reg.rx_tick + 5'h01;
      case (s_reg.rx_ph)
        DSP_PH_IDLE: begin
          s_next.rx_tick = 5'h00;
          if (s_reg.rx_stop_pend) begin
            s_next.rx_en        = 1'b0;
            s_next.rx_stop_pend = 1'b0;
          end else if (!rx_src) begin
            s_next.rx_ph   = DSP_PH_START;
            s_next.rx_tick = 5'h01;
          end
        end
        DSP_PH_START: begin
          if (rx_src) begin
            s_next.rx_ph = DSP_PH_IDLE;
          end else if (s_reg.rx_tick == START_DET) begin
            s_next.rx_ph   = DSP_PH_DATA;
            s_next.rx_tick = HALF_BIT - FULL_BIT + START_DET + 5'h01;
            s_next.rx_bit  = 4'h0;
          end
        end
        DSP_PH_DATA: begin
          if (s_reg.rx_tick == FULL_BIT) begin
            s_next.rx_tick = 5'h01;
            s_next.rx_sh   = {rx_src, s_reg.rx_sh[7:1]};
            s_next.rx_bit  = s_reg.rx_bit + 4'h1;
            if (s_reg.rx_bit == DATA_BITS - 4'h1) begin
              s_next.rx_ph = chk_kind[2] ? DSP_PH_STOP : DSP_PH_CHECK;
            end
          end
        end
        DSP_PH_CHECK: begin
          if (s_reg.rx_tick == FULL_BIT) begin
            s_next.rx_tick = 5'h01;
            s_next.rx_par  = rx_src;
            s_next.rx_ph   = DSP_PH_STOP;
          end
        end
        default: begin
          if (s_reg.rx_tick == FULL_BIT) begin
            s_next.rx_ph    = DSP_PH_IDLE;
            s_next.rx_char  = s_reg.rx_sh;
            s_next.rx_ready = 1'b1;
            if (s_reg.rx_ready) s_next.err_ovr = 1'b1;
            if (!rx_src) s_next.err_frm = 1'b1;
            if (!chk_kind[2] && s_reg.rx_par != check_bit(chk_kind, s_reg.rx_sh)) begin
              s_next.err_chk = 1'b1;
            end
          end
        end
      endcase
    end

    // ---- Transmitter
    if (s_reg.tx_en && samp_en) begin
      s_next.tx_tick = s_reg.tx_tick + 4'h1;
      if (s_reg.tx_tick == 4'hF) begin
        case (s_reg.tx_ph)
          DSP_PH_START: begin
            s_next.tx_ph   = DSP_PH_DATA;
            s_next.tx_line = s_reg.tx_sh[0];
            s_next.tx_bit  = 4'h1;
          end
          DSP_PH_DATA: begin
            if (s_reg.tx_bit == DATA_BITS) begin
              s_next.tx_ph   = chk_kind[2] ? DSP_PH_STOP : DSP_PH_CHECK;
              s_next.tx_line = chk_kind[2] ? 1'b1 : s_reg.tx_par;
            end else begin
              s_next.tx_line = s_reg.tx_sh[s_reg.tx_bit[2:0]];
              s_next.tx_bit  = s_reg.tx_bit + 4'h1;
            end
          end
          DSP_PH_CHECK: begin
            s_next.tx_ph   = DSP_PH_STOP;
            s_next.tx_line = 1'b1;
          end
          default: s_next.tx_ph = DSP_PH_IDLE;
        endcase
      end
      if (s_reg.tx_ph == DSP_PH_IDLE) begin
        s_next.tx_tick = 4'h0;
        if (s_reg.tx_hold_full) begin
          s_next.tx_sh        = s_reg.tx_hold;
          s_next.tx_par       = check_bit(chk_kind, s_reg.tx_hold);
          // A write in this very cycle refills the holding register
          s_next.tx_hold_full = write_in && (addr_in == OFF_TX_CHAR);
          s_next.tx_ph        = DSP_PH_START;
          s_next.tx_line      = 1'b0;
        end else if (s_reg.tx_stop_pend) begin
          s_next.tx_en        = 1'b0;
          s_next.tx_stop_pend = 1'b0;
        end
      end
    end

    // ---- Commands; disable beats enable, reset beats all
    if (wr_cmd) begin
      if (wdata_in[CMD_RX_ON] && !wdata_in[CMD_RX_OFF]) begin
        s_next.rx_en        = 1'b1;
        s_next.rx_stop_pend = 1'b0;
      end
      if (wdata_in[CMD_RX_OFF]) begin
        if (s_reg.rx_ph == DSP_PH_IDLE) s_next.rx_en = 1'b0;
        else s_next.rx_stop_pend = s_reg.rx_en;
      end
      if (wdata_in[CMD_TX_ON] && !wdata_in[CMD_TX_OFF]) begin
        s_next.tx_en        = 1'b1;
        s_next.tx_stop_pend = 1'b0;
      end
      if (wdata_in[CMD_TX_OFF]) begin
        if (s_reg.tx_ph == DSP_PH_IDLE && !s_reg.tx_hold_full) s_next.tx_en = 1'b0;
        else s_next.tx_stop_pend = s_reg.tx_en;
      end
      if (wdata_in[CMD_RX_RST]) begin
        s_next.rx_en        = 1'b0;
        s_next.rx_stop_pend = 1'b0;
        s_next.rx_ph        = DSP_PH_IDLE;
        s_next.rx_ready     = 1'b0;
      end
      if (wdata_in[CMD_TX_RST]) begin
        s_next.tx_en        = 1'b0;
        s_next.tx_stop_pend = 1'b0;
        s_next.tx_ph        = DSP_PH_IDLE;
        s_next.tx_hold_full = 1'b0;
        s_next.tx_line      = 1'b1;
      end
    end

    // ---- Output pin routing
    case (mode)
      DSP_MODE_ECHO:   s_next.out_pin = s_reg.rx_line;
      DSP_MODE_LOCAL:  s_next.out_pin = 1'b1;
      DSP_MODE_REMOTE: s_next.out_pin = s_reg.rx_line;
      default:         s_next.out_pin = s_reg.tx_line;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      s_reg              <= '0;
      s_reg.sync         <= 3'b111;
      s_reg.rx_line      <= 1'b1;
      s_reg.tx_line      <= 1'b1;
      s_reg.out_pin      <= 1'b1;
      s_reg.rx_ph        <= DSP_PH_IDLE;
      s_reg.tx_ph        <= DSP_PH_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata_out          = s_reg.rdata;
  assign serial_out_pin_out = s_reg.out_pin;
  assign rx_channel_req_out = flags[FL_RX_READY];
  assign tx_channel_req_out = flags[FL_TX_FREE];
  assign tap_reset_n_out    = !s_reg.tap_lock;
  assign irq_out            = |(flags & s_reg.mask);

  // ==========================================================
  // Assertions
  property p_irq_gate;
    @(posedge clock_in) disable iff (!nrst_in)
      (s_reg.mask[FL_DCC_RD] && dcc_read_pending_in) ||
      (s_reg.mask[FL_DCC_WR] && dcc_write_pending_in) |-> irq_out;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq mismatch");

  property p_mask_set;
    @(posedge clock_in) disable iff (!nrst_in)
      write_in && addr_in == OFF_IRQ_SET && wdata_in[FL_DCC_RD] |=> s_reg.mask[FL_DCC_RD];
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask not set");

  property p_mask_clr;
    @(posedge clock_in) disable iff (!nrst_in)
      write_in && addr_in == OFF_IRQ_CLR && wdata_in[FL_RX_READY] |=> !s_reg.mask[FL_RX_READY];
  endproperty
  a_mask_clr: assert property (p_mask_clr) else $error("mask not cleared");

  property p_rx_read_clear;
    @(posedge clock_in) disable iff (!nrst_in)
      read_in && addr_in == OFF_RX_CHAR && !rx_done |=> !rx_channel_req_out;
  endproperty
  a_rx_read_clear: assert property (p_rx_read_clear) else $error("ready stuck");

  property p_tap;
    @(posedge clock_in) disable iff (!nrst_in)
      write_in && addr_in == OFF_TAP_LOCK && wdata_in[0] |=> !tap_reset_n_out;
  endproperty
  a_tap: assert property (p_tap) else $error("tap reset not held");

  property p_local_high;
    @(posedge clock_in) disable iff (!nrst_in)
      mode == DSP_MODE_LOCAL ##1 mode == DSP_MODE_LOCAL |-> serial_out_pin_out;
  endproperty
  a_local_high: assert property (p_local_high) else $error("local loop pin low");

  property p_err_clr;
    @(posedge clock_in) disable iff (!nrst_in)
      wr_cmd && wdata_in[CMD_ERR_CLR] && !rx_done |=> !s_reg.err_frm && !s_reg.err_chk;
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("errors not cleared");

  property p_rx_rst;
    @(posedge clock_in) disable iff (!nrst_in)
      wr_cmd && wdata_in[CMD_RX_RST] |=> !s_reg.rx_en && s_reg.rx_ph == DSP_PH_IDLE;
  endproperty
  a_rx_rst: assert property (p_rx_rst) else $error("receiver not reset");

  property p_tx_rst;
    @(posedge clock_in) disable iff (!nrst_in)
      wr_cmd && wdata_in[CMD_TX_RST] |=> !s_reg.tx_en ##1 serial_out_pin_out || mode != DSP_MODE_NORMAL;
  endproperty
  a_tx_rst: assert property (p_tx_rst) else $error("transmitter not reset");

  property p_en_dis;
    @(posedge clock_in) disable iff (!nrst_in)
      wr_cmd && wdata_in[CMD_TX_ON] && wdata_in[CMD_TX_OFF] && !s_reg.tx_en |=> !s_reg.tx_en;
  endproperty
  a_en_dis: assert property (p_en_dis) else $error("disable lost");

  c_rx_char: cover property (@(posedge clock_in) disable iff (!nrst_in) $rose(s_reg.rx_ready));
  c_tx_start: cover property (@(posedge clock_in) disable iff (!nrst_in)
    s_reg.tx_ph == DSP_PH_START);
  c_echo: cover property (@(posedge clock_in) disable iff (!nrst_in) mode == DSP_MODE_ECHO);
  c_overrun: cover property (@(posedge clock_in) disable iff (!nrst_in) $rose(s_reg.err_ovr));
endmodule : dsp_debug_port
`default_nettype wire

//--- testbench/dsp_term_model.sv
// Serial terminal model facing the debug port pins
`timescale 1ns/1ps
`default_nettype none
module dsp_term_model #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic       clock_in,
  input  wire logic       line_in,
  output logic            line_out,
  output logic [7:0]      got_out,
  output int              n_got_out
);
  initial begin
    line_out  = 1'b1;
    got_out   = 8'h00;
    n_got_out = 0;
  end
  // Low start, data LSB first, high stop; no check bit, so a setup that expects one takes the stop bit as its check bit
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clock_in);
      line_out <= f[i];
      repeat (BIT_CLKS - 1) @(posedge clock_in);
    end
  endtask : send
  // Mid-bit sampling, so a few clocks of pin lag do no harm
  always begin
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge clock_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clock_in);
      got_out[i] = line_in;
    end
    repeat (BIT_CLKS) @(posedge clock_in);
    n_got_out = n_got_out + 1;
  end
endmodule : dsp_term_model
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench of the debug serial port
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  import dsp_pkg::*;
  logic        clock_in = 1'b0;
  logic        nrst_in  = 1'b0;
  logic        write_in = 1'b0;
  logic        read_in  = 1'b0;
  logic [7:0]  addr     = 8'h00;
  logic [31:0] wdata    = 32'h0000_0000;
  logic [31:0] rdata;
  logic [5:0]  src      = 6'h00;
  logic        ser_in, ser_out, rx_req, tx_req, tap_n, irq;
  logic [7:0]  got;
  int          n_got, n_mismatch = 0, compares = 0;
  always #50 clock_in = ~clock_in;
  dsp_debug_port dsp_debug_port_i (.clock_in(clock_in), .nrst_in(nrst_in),
    .addr_in(addr), .wdata_in(wdata), .write_in(write_in), .read_in(read_in),
    .rdata_out(rdata), .serial_in_pin_in(ser_in), .serial_out_pin_out(ser_out),
    .dcc_read_pending_in(src[5]), .dcc_write_pending_in(src[4]),
    .rx_channel_done_in(src[0]), .tx_channel_done_in(src[1]),
    .tx_channel_buffer_empty_in(src[2]), .rx_channel_buffer_full_in(src[3]),
    .rx_channel_req_out(rx_req), .tx_channel_req_out(tx_req),
    .tap_reset_n_out(tap_n), .irq_out(irq));
  dsp_term_model #(.BIT_CLKS(16)) dsp_term_model_i (.clock_in(clock_in),
    .line_in(ser_out), .line_out(ser_in), .got_out(got), .n_got_out(n_got));
  // ==========================================
  // Bus tasks
  task automatic clks(input int n);
    repeat (n) @(posedge clock_in);
  endtask : clks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr     <= a;
    wdata    <= d;
    write_in <= 1'b1;
    @(posedge clock_in);
    write_in <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_in);
    addr    <= a;
    read_in <= 1'b1;
    @(posedge clock_in);
    read_in <= 1'b0;
    #1 `CHK(rdata, e)
  endtask : rdc
  // Bounded waits: a stuck port is caught by the compare that follows
  task automatic wait_got(input int old);
    for (int i = 0; i < 600 && n_got == old; i++) @(posedge clock_in);
  endtask : wait_got
  task automatic wait_rx;
    for (int i = 0; i < 600 && rx_req !== 1'b1; i++) @(posedge clock_in);
  endtask : wait_rx
  // ==========================================
  // Scenarios
  task automatic t_regs;
    rdc(OFF_IRQ_MASK, RESET_ZERO);
    rdc(OFF_SETUP, RESET_ZERO);
    rdc(OFF_ID, ID_VALUE);
    rdc(OFF_ID_EXTRA, ID_EXTRA);
    wr(OFF_ID, RESET_ZERO);
    rdc(OFF_ID, ID_VALUE);
    rdc(8'h24, RESET_ZERO);
    `CHK(tap_n, 1'b1)
    wr(OFF_TAP_LOCK, 32'h0000_0001);
    clks(2);
    `CHK(tap_n, 1'b0)
    wr(OFF_TAP_LOCK, RESET_ZERO);
    clks(2);
    `CHK(tap_n, 1'b1)
  endtask : t_regs
  task automatic t_irq;
    int pos [6] = '{3, 4, 11, 12, 30, 31};
    wr(OFF_IRQ_SET, 32'hFFFF_FFFF);
    rdc(OFF_IRQ_MASK, SRC_MASK);
    wr(OFF_IRQ_CLR, 32'hFFFF_FFFF);
    rdc(OFF_IRQ_MASK, RESET_ZERO);
    for (int i = 0; i < 6; i++) begin
      @(posedge clock_in);
      src[i] <= 1'b1;
      clks(3);
      `CHK(irq, 1'b0)
      wr(OFF_IRQ_SET, 32'h1 << pos[i]);
      clks(2);
      `CHK(irq, 1'b1)
      wr(OFF_IRQ_CLR, 32'h1 << pos[i]);
      clks(2);
      `CHK(irq, 1'b0)
      src[i] <= 1'b0;
    end
  endtask : t_irq
  task automatic t_tx;
    int old;
    wr(OFF_DIVISOR, 32'h0000_0001);
    rdc(OFF_DIVISOR, 32'h0000_0001);
    wr(OFF_SETUP, 32'h0000_0800);
    wr(OFF_COMMAND, 32'h0000_00C0);
    clks(2);
    `CHK(tx_req, 1'b0)
    wr(OFF_COMMAND, 32'h0000_0040);
    clks(2);
    `CHK(tx_req, 1'b1)
    old = n_got;
    wr(OFF_TX_CHAR, 32'h0000_00A5);
    wait_got(old);
    `CHK(got, 8'hA5)
  endtask : t_tx
  task automatic t_rx;
    wr(OFF_COMMAND, 32'h0000_0010);
    dsp_term_model_i.send(8'h3C);
    wait_rx();
    `CHK(rx_req, 1'b1)
    rdc(OFF_RX_CHAR, 32'h0000_003C);
    `CHK(rx_req, 1'b0)
  endtask : t_rx
  task automatic t_loop;
    int old;
    logic [31:0] md [2] = '{32'h0000_4800, 32'h0000_C800};
    wr(OFF_SETUP, 32'h0000_8800);
    old = n_got;
    wr(OFF_TX_CHAR, 32'h0000_005A);
    wait_rx();
    rdc(OFF_RX_CHAR, 32'h0000_005A);
    `CHK(n_got, old)
    for (int i = 0; i < 2; i++) begin
      wr(OFF_SETUP, md[i]);
      old = n_got;
      dsp_term_model_i.send(8'h96 + 8'(i));
      wait_got(old);
      `CHK(got, 8'h96 + 8'(i))
    end
  endtask : t_loop
  task automatic t_cmd;
    rdc(OFF_RX_CHAR, 32'h0000_0096);
    wr(OFF_SETUP, RESET_ZERO);
    dsp_term_model_i.send(8'h3C);
    wait_rx();
    rdc(OFF_FLAGS, 32'h0000_0283);
    rdc(OFF_RX_CHAR, 32'h0000_003C);
    wr(OFF_COMMAND, 32'h0000_0100);
    rdc(OFF_FLAGS, 32'h0000_0202);
    wr(OFF_COMMAND, 32'h0000_000C);
    rdc(OFF_FLAGS, RESET_ZERO);
    wr(OFF_COMMAND, 32'h0000_0050);
    wr(OFF_SETUP, 32'h0000_8800);
    wr(OFF_TX_CHAR, 32'h0000_00C3);
    wr(OFF_COMMAND, 32'h0000_0080);
    wait_rx();
    rdc(OFF_RX_CHAR, 32'h0000_00C3);
    clks(16);
    rdc(OFF_FLAGS, RESET_ZERO);
    wr(OFF_COMMAND, 32'h0000_0040);
    wr(OFF_TX_CHAR, 32'h0000_0011);
    clks(40);
    wr(OFF_COMMAND, 32'h0000_0020);
    wait_rx();
    rdc(OFF_RX_CHAR, 32'h0000_0011);
    wr(OFF_TX_CHAR, 32'h0000_0022);
    clks(200);
    `CHK(rx_req, 1'b0)
  endtask : t_cmd
  task automatic test_done;
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (60000) @(posedge clock_in);
    n_mismatch++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge clock_in);
    nrst_in <= 1'b1;
    t_regs();
    t_irq();
    t_tx();
    t_rx();
    t_loop();
    t_cmd();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
